// ===== src/ebc_seq_consts.vh
`ifndef BUS_SEQ_CONSTS_VH
`define BUS_SEQ_CONSTS_VH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_TIMING 5'h00
`define OFS_CTRL 5'h04
`define OFS_ADDR 5'h08
`define OFS_WDATA 5'h0c
`define OFS_STATUS 5'h10
`define OFS_RDATA 5'h14
// ****************************************
// chip_select_timing_config fields
// ****************************************
`define TC_AB_LONG 0
`define TC_AB_EXT_LO 1
`define TC_AB_EXT_HI 2
`define TC_C_LO 3
`define TC_C_HI 4
`define TC_D 5
`define TC_E_LO 6
`define TC_E_HI 10
`define TC_F_LO 11
`define TC_F_HI 12
`define TC_RDY_EN 13
`define TC_RDY_POL 14
`define TC_RDY_ASYNC 15
`define TC_MUX 16
`define TC_WIDTH 17
`define TC_RESET 17'h007c0
// ****************************************
// control, status fields
// ****************************************
`define CTRL_START 0
`define CTRL_WRITE 1
`define CTRL_BHE 2
`define ST_BUSY 0
`define ST_DONE 1
// ****************************************
// widths and bus answers
// ****************************************
`define ADDR_W 24
`define DATA_W 16
`define WIN_HI 23
`define WIN_LO 16
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ===== src/ready_sampler.v
`timescale 1ns/1ns
// ****************************************
// ready input: polarity and optional synchroniser
// ****************************************
module ready_sampler (
   input wire clk,
   input wire rstn,
   input wire ready_in,
   input wire pol_high,
   input wire use_sync,
   output wire ready_active
);
   reg meta_ff;
   reg sync_ff;

   // meta_ff feeds only sync_ff
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= ready_in;
         sync_ff <= meta_ff;
      end
   end

   // polarity selected after the sync stage
   assign ready_active = use_sync ? (sync_ff == pol_high) : (ready_in == pol_high);
endmodule

// ===== src/ext_bus_sequencer.v
`timescale 1ns/1ns
`include "ebc_seq_consts.vh"
module ext_bus_sequencer (
   input wire clk,
   input wire rstn,
   // axi4-lite slave
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // external bus pins
   output reg chip_select_n,
   output reg read_strobe_n,
   output reg write_strobe_n,
   output reg addr_latch_strobe,
   output reg high_byte_enable_n,
   output reg [`ADDR_W-1:0] address_lines,
   input wire [`DATA_W-1:0] shared_addr_data_lines_in,
   output reg [`DATA_W-1:0] shared_addr_data_lines_out,
   output reg shared_addr_data_lines_oe_n,
   input wire [`DATA_W-1:0] dedicated_data_lines_in,
   output reg [`DATA_W-1:0] dedicated_data_lines_out,
   output reg dedicated_data_lines_oe_n,
   input wire ready_in
);
   // ****************************************
   // states
   // ****************************************
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_AB = 3'd1;
   localparam [2:0] ST_C = 3'd2;
   localparam [2:0] ST_D = 3'd3;
   localparam [2:0] ST_E = 3'd4;
   localparam [2:0] ST_WAIT = 3'd5;
   localparam [2:0] ST_F = 3'd6;

   reg [`TC_WIDTH-1:0] timing_ff;
   reg write_ff;
   reg bhe_ff;
   reg [`ADDR_W-1:0] addr_ff;
   reg [`DATA_W-1:0] wdata_ff;
   reg [`DATA_W-1:0] rdata_ff;
   reg done_ff;
   reg start_ff;
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [5:0] cnt_ff;
   reg [5:0] nxt_cnt;
   reg waited_ff;
   reg [7:0] last_win_ff;
   reg win_valid_ff;
   wire ready_active;

   // ****************************************
   // axi4-lite register access
   // ****************************************
   function [31:0] merge;
      input [31:0] old;
      input [31:0] val;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               merge[i*8 +: 8] = val[i*8 +: 8];
      end
   endfunction

   function mapped;
      input [4:0] a;
      begin
         mapped = (a == `OFS_TIMING) || (a == `OFS_CTRL) || (a == `OFS_ADDR) ||
                  (a == `OFS_WDATA) || (a == `OFS_STATUS) || (a == `OFS_RDATA);
      end
   endfunction

   wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire busy = (state_ff != ST_IDLE) || start_ff;
   // writes during a cycle are ignored for config, so the running cycle stays stable
   wire cfg_we = wr_go && !busy;
   wire [31:0] ctrl_merged = merge(32'h0, s_axi_wdata, s_axi_wstrb);
   wire start_req = cfg_we && (s_axi_awaddr == `OFS_CTRL) && ctrl_merged[`CTRL_START];
   wire [31:0] timing_merged = merge({15'h0, timing_ff}, s_axi_wdata, s_axi_wstrb);
   wire [31:0] addr_merged = merge({8'h0, addr_ff}, s_axi_wdata, s_axi_wstrb);
   wire [31:0] wdata_merged = merge({16'h0, wdata_ff}, s_axi_wdata, s_axi_wstrb);
   wire cycle_end;

   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         timing_ff <= `TC_RESET;
         write_ff <= 1'b0;
         bhe_ff <= 1'b0;
         addr_ff <= {`ADDR_W{1'b0}};
         wdata_ff <= {`DATA_W{1'b0}};
         start_ff <= 1'b0;
         done_ff <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         start_ff <= start_req;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(s_axi_awaddr) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (cfg_we) begin
            case (s_axi_awaddr)
               `OFS_TIMING: begin
                  timing_ff <= timing_merged[`TC_WIDTH-1:0];
               end
               `OFS_CTRL: begin
                  if (s_axi_wstrb[0]) begin
                     write_ff <= s_axi_wdata[`CTRL_WRITE];
                     bhe_ff <= s_axi_wdata[`CTRL_BHE];
                  end
               end
               `OFS_ADDR: begin
                  addr_ff <= addr_merged[`ADDR_W-1:0];
               end
               `OFS_WDATA: begin
                  wdata_ff <= wdata_merged[`DATA_W-1:0];
               end
               default: begin
               end
            endcase
         end
         // completion beats a clear that starts in the same cycle
         if (cycle_end)
            done_ff <= 1'b1;
         else if (start_req)
            done_ff <= 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
         case (s_axi_araddr)
            `OFS_TIMING: s_axi_rdata <= {15'h0, timing_ff};
            `OFS_CTRL: s_axi_rdata <= {29'h0, bhe_ff, write_ff, 1'b0};
            `OFS_ADDR: s_axi_rdata <= {8'h0, addr_ff};
            `OFS_WDATA: s_axi_rdata <= {16'h0, wdata_ff};
            `OFS_STATUS: s_axi_rdata <= {30'h0, done_ff, busy};
            `OFS_RDATA: s_axi_rdata <= {16'h0, rdata_ff};
            default: s_axi_rdata <= 32'h0;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // phase lengths, one unit per clock
   // ****************************************
   wire [1:0] c_len = timing_ff[`TC_C_HI:`TC_C_LO];
   wire d_len = timing_ff[`TC_D];
   wire [5:0] e_len = {1'b0, timing_ff[`TC_E_HI:`TC_E_LO]} + 6'd1;
   wire [1:0] f_len = timing_ff[`TC_F_HI:`TC_F_LO];
   wire rdy_en = timing_ff[`TC_RDY_EN];
   wire rdy_async = timing_ff[`TC_RDY_ASYNC];
   wire mux = timing_ff[`TC_MUX];
   wire win_change = !win_valid_ff || (addr_ff[`WIN_HI:`WIN_LO] != last_win_ff);
   // extension when the address window moves, and on the first cycle after reset
   wire [5:0] ab_len = {5'h0, timing_ff[`TC_AB_LONG]} + 6'd1 +
                       (win_change ? {4'h0, timing_ff[`TC_AB_EXT_HI:`TC_AB_EXT_LO]} : 6'd0);
   wire last_unit = (cnt_ff == 6'd1);
   wire access_end = ((state_ff == ST_E) && last_unit &&
                      (!rdy_en || (ready_active && !(rdy_async && !waited_ff)))) ||
                     ((state_ff == ST_WAIT) && ready_active);
   assign cycle_end = (access_end && (f_len == 2'd0)) || ((state_ff == ST_F) && last_unit);

   ready_sampler ready_sampler_inst (
      .clk(clk),
      .rstn(rstn),
      .ready_in(ready_in),
      .pol_high(timing_ff[`TC_RDY_POL]),
      .use_sync(rdy_async),
      .ready_active(ready_active)
   );

   // ****************************************
   // phase sequencer
   // ****************************************
   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff - 6'd1;
      case (state_ff)
         ST_IDLE: begin
            nxt_cnt = ab_len;
            if (start_ff)
               nxt_state = ST_AB;
         end
         ST_AB: begin
            if (last_unit) begin
               if (c_len != 2'd0) begin
                  nxt_state = ST_C;
                  nxt_cnt = {4'h0, c_len};
               end else if (d_len) begin
                  nxt_state = ST_D;
                  nxt_cnt = 6'd1;
               end else begin
                  nxt_state = ST_E;
                  nxt_cnt = e_len;
               end
            end
         end
         ST_C: begin
            if (last_unit) begin
               if (d_len) begin
                  nxt_state = ST_D;
                  nxt_cnt = 6'd1;
               end else begin
                  nxt_state = ST_E;
                  nxt_cnt = e_len;
               end
            end
         end
         ST_D: begin
            nxt_state = ST_E;
            nxt_cnt = e_len;
         end
         ST_E, ST_WAIT: begin
            if (state_ff == ST_WAIT)
               nxt_cnt = 6'd1;
            if (access_end) begin
               nxt_state = (f_len != 2'd0) ? ST_F : ST_IDLE;
               nxt_cnt = {4'h0, f_len};
            end else if (state_ff == ST_WAIT || last_unit) begin
               // a synchronised ready always costs one wait first
               nxt_state = ST_WAIT;
               nxt_cnt = 6'd1;
            end
         end
         ST_F: begin
            if (last_unit)
               nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
         cnt_ff <= 6'd0;
         waited_ff <= 1'b0;
         last_win_ff <= 8'h0;
         win_valid_ff <= 1'b0;
         rdata_ff <= {`DATA_W{1'b0}};
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         waited_ff <= (state_ff == ST_WAIT) || (waited_ff && state_ff != ST_IDLE);
         if (state_ff == ST_AB && last_unit) begin
            last_win_ff <= addr_ff[`WIN_HI:`WIN_LO];
            win_valid_ff <= 1'b1;
         end
         // sampled on the edge that lifts the read strobe; nothing later is looked at
         if (access_end && !write_ff)
            rdata_ff <= mux ? shared_addr_data_lines_in : dedicated_data_lines_in;
      end
   end

   // ****************************************
   // registered pin drive from next phase
   // ****************************************
   wire in_cycle = (nxt_state != ST_IDLE);
   wire in_cmd = (nxt_state == ST_E) || (nxt_state == ST_WAIT);
   wire data_phase = (nxt_state == ST_D) || in_cmd || (nxt_state == ST_F);

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chip_select_n <= 1'b1;
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         addr_latch_strobe <= 1'b0;
         high_byte_enable_n <= 1'b1;
         address_lines <= {`ADDR_W{1'b0}};
         shared_addr_data_lines_out <= {`DATA_W{1'b0}};
         shared_addr_data_lines_oe_n <= 1'b1;
         dedicated_data_lines_out <= {`DATA_W{1'b0}};
         dedicated_data_lines_oe_n <= 1'b1;
      end else begin
         chip_select_n <= !in_cycle;
         read_strobe_n <= !(in_cmd && !write_ff);
         write_strobe_n <= !(in_cmd && write_ff);
         high_byte_enable_n <= !(in_cycle && bhe_ff);
         addr_latch_strobe <= mux && (nxt_state == ST_AB);
         // read data is held in rdata_ff; address_lines loads addr_ff only in setup and holds it until the next setup
         if (nxt_state == ST_AB)
            address_lines <= addr_ff;
         if (mux) begin
            // address during setup, then write data; read turns the bus around
            if (nxt_state == ST_AB) begin
               shared_addr_data_lines_out <= addr_ff[`DATA_W-1:0];
               shared_addr_data_lines_oe_n <= 1'b0;
            end else if (data_phase && write_ff) begin
               shared_addr_data_lines_out <= wdata_ff;
               shared_addr_data_lines_oe_n <= 1'b0;
            end else begin
               shared_addr_data_lines_oe_n <= 1'b1;
            end
            dedicated_data_lines_oe_n <= 1'b1;
         end else begin
            shared_addr_data_lines_oe_n <= 1'b1;
            dedicated_data_lines_out <= wdata_ff;
            dedicated_data_lines_oe_n <= !(data_phase && write_ff);
         end
      end
   end
endmodule

// ===== sim/ext_bus_checker.sv
`timescale 1ns/1ns
`include "ebc_seq_consts.vh"
// ********
// pin sequencing checks
// ********
module ext_bus_checker (
   input wire clk,
   input wire rstn,
   input wire chip_select_n,
   input wire read_strobe_n,
   input wire write_strobe_n,
   input wire addr_latch_strobe,
   input wire high_byte_enable_n,
   input wire [`ADDR_W-1:0] address_lines,
   input wire [`DATA_W-1:0] shared_addr_data_lines_out,
   input wire shared_addr_data_lines_oe_n,
   input wire dedicated_data_lines_oe_n
);
   wire cmd_on = !read_strobe_n || !write_strobe_n;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence cmd_end;
      $rose(read_strobe_n) || $rose(write_strobe_n);
   endsequence
   sequence select_off;
      ##[0:3] chip_select_n;
   endsequence
   strobe_in_cs_a: assert property (cmd_on |-> !chip_select_n)
      else $error("command strobe outside select");
   one_strobe_a: assert property (read_strobe_n || write_strobe_n)
      else $error("read and write strobe together");
   bhe_in_cs_a: assert property (!high_byte_enable_n |-> !chip_select_n)
      else $error("byte enable outside select");
   ale_addr_a: assert property (addr_latch_strobe |->
      !shared_addr_data_lines_oe_n && shared_addr_data_lines_out == address_lines[15:0])
      else $error("latch strobe without address on shared lines");
   ale_no_cmd_a: assert property (addr_latch_strobe |-> !cmd_on)
      else $error("latch strobe during command");
   setup_first_a: assert property ($fell(chip_select_n) |-> !cmd_on)
      else $error("no address setup before command");
   addr_steady_a: assert property (!chip_select_n && $past(!chip_select_n) |->
      $stable(address_lines))
      else $error("address moved inside cycle");
   hold_end_a: assert property (cmd_end |-> select_off)
      else $error("hold phase longer than three units");
   wdata_drive_a: assert property (!write_strobe_n |->
      !(shared_addr_data_lines_oe_n && dedicated_data_lines_oe_n))
      else $error("write strobe with no data driven");
   read_float_a: assert property (!read_strobe_n |->
      shared_addr_data_lines_oe_n && dedicated_data_lines_oe_n)
      else $error("data driven during read");
endmodule
bind ext_bus_sequencer ext_bus_checker ext_bus_checker_inst (.*);

// ===== sim/ext_mem_model.sv
`timescale 1ns/1ns
// ********
// external memory with ready handshake
// ********
module ext_mem_model (
   input wire clk,
   input wire read_strobe_n,
   input wire write_strobe_n,
   input wire [23:0] address_lines,
   input wire [15:0] shared_addr_data_lines_out,
   input wire [15:0] dedicated_data_lines_out,
   input wire mux_mode,
   input wire rdy_pol,
   input wire [3:0] rdy_wait,
   output wire [15:0] mem_data,
   output wire ready_in
);
   reg [15:0] mem_ff [0:15];
   reg [15:0] last_ff = 16'h0000;
   reg [3:0] wait_ff = 4'h0;
   wire cmd_on = !read_strobe_n || !write_strobe_n;
   // ready only inside a command, so it is gone before the next sample point
   assign ready_in = rdy_pol ~^ (cmd_on && wait_ff >= rdy_wait);
   // released lines show the inverse, never a stale copy
   assign mem_data = read_strobe_n ? ~last_ff : mem_ff[address_lines[3:0]];
   always @(posedge clk) begin
      wait_ff <= cmd_on ? wait_ff + 4'h1 : 4'h0;
      if (!read_strobe_n)
         last_ff <= mem_ff[address_lines[3:0]];
      if (!write_strobe_n)
         mem_ff[address_lines[3:0]] <= mux_mode ? shared_addr_data_lines_out :
            dedicated_data_lines_out;
   end
endmodule

// ===== sim/tb_ext_bus_sequencer.sv
`timescale 1ns/1ns
`include "ebc_seq_consts.vh"
module tb_ext_bus_sequencer;
   reg clk = 1'b0;
   reg rstn = 1'b0;
   reg [4:0] s_axi_awaddr = 5'h00;
   reg [4:0] s_axi_araddr = 5'h00;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_awvalid = 1'b0;
   reg s_axi_wvalid = 1'b0;
   reg s_axi_arvalid = 1'b0;
   reg s_axi_bready = 1'b1;
   reg s_axi_rready = 1'b1;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire chip_select_n, read_strobe_n, write_strobe_n, addr_latch_strobe, high_byte_enable_n;
   wire [23:0] address_lines;
   wire [15:0] shared_addr_data_lines_out, dedicated_data_lines_out, mem_data;
   wire shared_addr_data_lines_oe_n, dedicated_data_lines_oe_n, ready_in;
   reg mux_mode = 1'b0;
   reg rdy_pol = 1'b0;
   reg [3:0] rdy_wait = 4'h0;
   // wire level: the enabled driver wins, else the memory
   wire [15:0] shared_addr_data_lines_in = shared_addr_data_lines_oe_n ? mem_data :
      shared_addr_data_lines_out;
   wire [15:0] dedicated_data_lines_in = dedicated_data_lines_oe_n ? mem_data :
      dedicated_data_lines_out;
   integer bad_count = 0;
   integer tests_run = 0;
   integer cycles = 0;
   integer cs_cnt = 0;
   integer cmd_cnt = 0;
   integer bhe_cnt = 0;
   integer i;
   reg [31:0] rd;
   reg [1:0] resp;
   reg [8:0] last_win = 9'h100;
   reg [16:0] cfg [0:5];
   reg [3:0] kw [0:5];
   ext_bus_sequencer ext_bus_sequencer_inst (.*);
   ext_mem_model ext_mem_model_inst (.*);
   always #10 clk = ~clk;
   // ceiling well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      cs_cnt <= cs_cnt + (chip_select_n ? 0 : 1);
      cmd_cnt <= cmd_cnt + ((read_strobe_n && write_strobe_n) ? 0 : 1);
      bhe_cnt <= bhe_cnt + (high_byte_enable_n ? 0 : 1);
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         complete_run;
      end
   end
   task complete_run;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, bad_count);
         if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task check(input string what, input [31:0] exp, input [31:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task axi_wr(input [4:0] a, input [31:0] d);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         do @(posedge clk); while (!s_axi_awready);
         s_axi_awvalid <= 1'b0;
         s_axi_wvalid <= 1'b0;
         do @(posedge clk); while (!s_axi_bvalid);
         resp = s_axi_bresp;
      end
   endtask
   task axi_rd(input [4:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         do @(posedge clk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         do @(posedge clk); while (!s_axi_rvalid);
         rd = s_axi_rdata;
         resp = s_axi_rresp;
      end
   endtask
   task bus_op(input wr, input [23:0] a, input [16:0] t, input [3:0] k);
      integer ab, e, en, cb, mb, hb;
      begin
         ab = 1 + t[0] + ((a[23:16] != last_win) ? t[2:1] : 0);
         last_win = {1'b0, a[23:16]};
         e = t[10:6] + 1;
         en = (t[13] && k >= e) ? k + 1 : e;
         cb = cs_cnt;
         mb = cmd_cnt;
         hb = bhe_cnt;
         axi_wr(`OFS_ADDR, {8'h00, a});
         axi_wr(`OFS_WDATA, {16'h0000, a[15:0] ^ 16'hc3a5});
         // reads also ask for the high byte, writes do not
         axi_wr(`OFS_CTRL, wr ? 32'h3 : 32'h5);
         do axi_rd(`OFS_STATUS); while (rd[1:0] !== 2'b10);
         mb = cmd_cnt - mb;
         check("phases", ab + t[4:3] + t[5] + t[12:11], cs_cnt - cb - mb);
         check("access", 1, t[15] ? (mb > en && mb <= en + 3) : (mb == en));
         check("byte enable", wr ? 0 : ab + t[4:3] + t[5] + t[12:11] + mb, bhe_cnt - hb);
         if (!wr) begin
            axi_rd(`OFS_RDATA);
            check("read data", {16'h0000, a[15:0] ^ 16'hc3a5}, rd);
         end
      end
   endtask
   initial begin
      cfg[0] = 17'h00000;
      cfg[1] = 17'h01fff;
      cfg[2] = 17'h1086c;
      cfg[3] = 17'h07010;
      cfg[4] = 17'h12040;
      cfg[5] = 17'h0e000;
      kw[0] = 4'h0;
      kw[1] = 4'h0;
      kw[2] = 4'h0;
      kw[3] = 4'h3;
      kw[4] = 4'h0;
      kw[5] = 4'h0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      axi_rd(`OFS_TIMING);
      check("timing reset", `TC_RESET, rd);
      axi_rd(5'h18);
      check("unmapped resp", `RESP_SLVERR, resp);
      for (i = 0; i < 6; i = i + 1) begin
         mux_mode <= cfg[i][16];
         rdy_pol <= cfg[i][14];
         rdy_wait <= kw[i];
         axi_wr(`OFS_TIMING, cfg[i]);
         check("write resp", `RESP_OKAY, resp);
         axi_rd(`OFS_TIMING);
         check("timing", cfg[i], rd);
         bus_op(1'b1, {4'h0, i[3:0], 12'h000, i[3:0]}, cfg[i], kw[i]);
         bus_op(1'b0, {4'h0, i[3:0], 12'h000, i[3:0]}, cfg[i], kw[i]);
         $display("test %0d done", i);
      end
      axi_wr(`OFS_TIMING, 32'h1fff);
      axi_wr(`OFS_CTRL, 32'h1);
      axi_wr(`OFS_TIMING, 32'h0);
      axi_rd(`OFS_TIMING);
      check("timing while busy", 32'h1fff, rd);
      do axi_rd(`OFS_STATUS); while (rd[1:0] !== 2'b10);
      $display("test busy done");
      complete_run;
   end
endmodule
